// ### hdl/disk_pos_params.svh
// Register offsets, field positions, function codes and timing counts
`ifndef DISK_POS_PARAMS_SVH
`define DISK_POS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_DCYL 8'h08
`define REG_DADDR 8'h0c
`define REG_CCYL 8'h10
`define REG_CFG 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_GO 0
`define CTRL_FN_LO 1
`define CTRL_FN_HI 5
`define STAT_GO 0
`define STAT_ATTN 1
`define STAT_BADADDR 2
`define STAT_FOUND 3
`define STAT_HOLD 4
`define STAT_ONLINE 5
`define DADDR_TRK_LO 8
`define DADDR_TRK_HI 12
`define CFG_FMT16 0
`define CFG_DIAG_SEL 1
`define CFG_DIAG_SCLK 2
`define CFG_DIAG_IDX 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFG_RESET 4'h0
`define CYL_RESET 9'h000

// ----------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------
`define FN_RECAL 5'h01
`define FN_UNLOAD 5'h02
`define FN_RTC 5'h03
`define FN_SEEK 5'h04
`define FN_OFFSET 5'h06
`define FN_WRITE 5'h0a
`define FN_SEARCH 5'h0c

// ----------------------------------------------------------------
// Timing and address limits
// ----------------------------------------------------------------
`define CLKS_18 10'h260
`define CLKS_16 10'h29f
`define LAST_18 5'h13
`define LAST_16 5'h15
`define MAX_CYL 9'h19a
`define MAX_TRK 5'h12
`define PHASE_ONE 2'h1
`define PHASE_TWO 2'h2
`define PHASE_THREE 2'h3

`endif

// ### hdl/disk_pos_pkg.sv
// Types shared by the positioner and sector search block
package disk_pos_pkg;

    // ------------------------------------------------------------
    // Bus and drive carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apbIn_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apbOut_s;

    typedef struct packed {
        logic sectClk;      // Drive sector clock
        logic indexPulse;   // Drive index pulse
        logic offsetReady;  // Heads on centerline
        logic posReady;     // Heads positioned (file ready)
        logic online;       // Drive on line
    } drvIn_s;

    typedef struct packed {
        logic offsetResetPulse;
        logic recalPulse;
        logic seekGo;
        logic standbyReq;
    } drvOut_s;

    // ------------------------------------------------------------
    // Command sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RTC,
        ST_RECAL,
        ST_UNLOAD,
        ST_UNLOAD_UP,
        ST_CHECK,
        ST_SEEK,
        ST_ISEEK,
        ST_SEARCH
    } cmd_e;

    // ------------------------------------------------------------
    // Whole block state
    // ------------------------------------------------------------
    typedef struct packed {
        apbOut_s apb;
        drvOut_s drv;
        cmd_e st;
        logic [4:0] cmd;
        logic go;
        logic attn;
        logic addrErr;
        logic found;
        logic offsetMode;
        logic offsetHold;
        logic moveReq;
        logic armed;
        logic retSeek;
        logic [1:0] moveCnt;
        logic [8:0] dcyl;
        logic [8:0] ccyl;
        logic [4:0] trk;
        logic [4:0] dsec;
        logic [4:0] sectCnt;
        logic [9:0] clkCnt;
        logic sectPulse;
        logic sectMatch;
        logic sClkPrev;
        logic idxPrev;
        logic [3:0] cfg;
    } state_s;

endpackage : disk_pos_pkg

// ### hdl/disk_positioner.sv
// Head positioning sequencer and sector search with APB registers
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "disk_pos_params.svh"
// Behaviour
// - Centerline return: explicit, or seek/write offset
// - Move request drives three-phase sector-clocked counter
// - Phase one of return pulses offset reset
// - Offset ready ends return: go off, attention
// - Implied return drops hold, resumes caller
// - Mode drops at phase three; hold until ready
// - Seek waits for hold drop before moving
// - Recal phase one pulses drive, clears cylinder
// - File ready ends recal: go off, attention
// - Unload requests standby; drive goes off line
// - Unload ends on online and file ready
// - Index and sector clock via diag selector
// - Index sets pulse, clears both counters
// - Clock count 608/671 restarts, makes pulse
// - Sector count 19/21 marks last sector
// - Last sector: only index makes pulse zero
// - Illegal search address sets error, aborts
// - Cylinder mismatch runs implied seek first
// - Pulse leading edge counts, compares sector
// - Trailing edge sets found; search completes
// - Limits: cylinder 410, track 18, sector 19/21
// - Implied seek end loads current cylinder
module disk_positioner (
    input wire logic clock,
    input wire logic rst,
    input wire disk_pos_pkg::apbIn_s apbIn,
    output disk_pos_pkg::apbOut_s apbOut,
    input wire disk_pos_pkg::drvIn_s drvIn,
    output disk_pos_pkg::drvOut_s drvOut
);
    import disk_pos_pkg::*;

    // ------------------------------------------------------------
    // State and working signals
    // ------------------------------------------------------------
    state_s s_q;          // Registered state
    state_s s_d;          // Next state
    logic sClk;           // Selected sector clock level
    logic idx;            // Selected index level
    logic sEdge;          // Sector clock rising edge
    logic iEdge;          // Index rising edge
    logic fmt16;          // 16-bit format selected
    logic lastSec;        // Final sector of revolution
    logic illegal;        // Desired address out of range
    logic access;         // APB access cycle being answered
    logic [4:0] fn;       // Function code being written
    logic [4:0] secNext;  // Sector count after increment
    logic [9:0] clkLimit; // Clock count ending a sector
    logic [4:0] secLimit; // Last sector number

    assign apbOut = s_q.apb;
    assign drvOut = s_q.drv;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Pulses and bus answer last one cycle
        s_d.apb.pready = 1'b0;
        s_d.apb.pslverr = 1'b0;
        s_d.drv.offsetResetPulse = 1'b0;
        s_d.drv.recalPulse = 1'b0;
        s_d.drv.seekGo = 1'b0;
        fmt16 = s_q.cfg[`CFG_FMT16];
        clkLimit = fmt16 ? `CLKS_16 : `CLKS_18;
        secLimit = fmt16 ? `LAST_16 : `LAST_18;
        // Diagnostic or drive source
        if (s_q.cfg[`CFG_DIAG_SEL]) begin
            sClk = s_q.cfg[`CFG_DIAG_SCLK];
            idx = s_q.cfg[`CFG_DIAG_IDX];
        end else begin
            sClk = drvIn.sectClk;
            idx = drvIn.indexPulse;
        end
        s_d.sClkPrev = sClk;
        s_d.idxPrev = idx;
        sEdge = sClk & ~s_q.sClkPrev;
        iEdge = idx & ~s_q.idxPrev;
        lastSec = (s_q.sectCnt == secLimit);
        secNext = s_q.sectCnt + 5'h01;
        illegal = (s_q.dcyl > `MAX_CYL) || (s_q.trk > `MAX_TRK)
            || (s_q.dsec > secLimit);
        fn = apbIn.pwdata[`CTRL_FN_HI:`CTRL_FN_LO];

        // --------------------------------------------------------
        // APB slave: answer one cycle into the access phase
        // --------------------------------------------------------
        access = apbIn.psel & apbIn.penable & ~s_q.apb.pready;
        if (access) begin
            s_d.apb.pready = 1'b1;
            s_d.apb.prdata = 32'h0000_0000;
            case (apbIn.paddr)
                `REG_CTRL: begin
                    s_d.apb.prdata = {26'h0, s_q.cmd, s_q.go};
                    // Start only when idle and code is known
                    if (apbIn.pwrite && apbIn.pwdata[`CTRL_GO] && !s_q.go) begin
                        s_d.cmd = fn;
                        s_d.found = 1'b0;
                        s_d.armed = 1'b0;
                        s_d.retSeek = 1'b0;
                        s_d.go = 1'b1;
                        case (fn)
                            `FN_RTC: begin
                                s_d.st = ST_RTC;
                                s_d.moveReq = 1'b1;
                            end
                            `FN_RECAL: begin
                                s_d.st = ST_RECAL;
                                s_d.moveReq = 1'b1;
                            end
                            `FN_UNLOAD: s_d.st = ST_UNLOAD;
                            `FN_SEEK: s_d.st = ST_SEEK;
                            `FN_SEARCH: s_d.st = ST_CHECK;
                            `FN_WRITE: s_d.st = ST_CHECK;
                            `FN_OFFSET: begin
                                // Offset move itself is outside this block
                                s_d.offsetMode = 1'b1;
                                s_d.offsetHold = 1'b1;
                                s_d.go = 1'b0;
                                s_d.attn = 1'b1;
                            end
                            default: s_d.go = 1'b0;
                        endcase
                    end
                end
                `REG_STAT: begin
                    s_d.apb.prdata = {26'h0, drvIn.online, s_q.offsetHold,
                        s_q.found, s_q.addrErr, s_q.attn, s_q.go};
                    // Write one to clear; later hardware sets win
                    if (apbIn.pwrite) begin
                        if (apbIn.pwdata[`STAT_ATTN])
                            s_d.attn = 1'b0;
                        if (apbIn.pwdata[`STAT_BADADDR])
                            s_d.addrErr = 1'b0;
                    end
                end
                `REG_DCYL: begin
                    s_d.apb.prdata = {23'h0, s_q.dcyl};
                    if (apbIn.pwrite && !s_q.go)
                        s_d.dcyl = apbIn.pwdata[8:0];
                end
                `REG_DADDR: begin
                    s_d.apb.prdata = {19'h0, s_q.trk, 3'h0, s_q.dsec};
                    if (apbIn.pwrite && !s_q.go) begin
                        s_d.trk = apbIn.pwdata[`DADDR_TRK_HI:`DADDR_TRK_LO];
                        s_d.dsec = apbIn.pwdata[4:0];
                    end
                end
                `REG_CCYL: s_d.apb.prdata = {23'h0, s_q.ccyl};
                `REG_CFG: begin
                    s_d.apb.prdata = {28'h0, s_q.cfg};
                    if (apbIn.pwrite)
                        s_d.cfg = apbIn.pwdata[3:0];
                end
                default: s_d.apb.pslverr = 1'b1; // Unmapped
            endcase
        end

        // --------------------------------------------------------
        // Sector timing
        // --------------------------------------------------------
        if (iEdge) begin
            // New revolution gives sector pulse zero
            s_d.clkCnt = 10'h000;
            s_d.sectCnt = 5'h00;
            s_d.sectPulse = 1'b1;
            s_d.sectMatch = (s_q.dsec == 5'h00);
        end else if (sEdge) begin
            // Trailing edge of a sector pulse
            if (s_q.sectPulse) begin
                s_d.sectPulse = 1'b0;
                if (s_q.sectMatch && s_q.st == ST_SEARCH)
                    s_d.found = 1'b1;
            end
            if (s_q.clkCnt == clkLimit) begin
                s_d.clkCnt = 10'h000;
                // No pulse inside the last sector
                if (!lastSec) begin
                    s_d.sectPulse = 1'b1;
                    s_d.sectCnt = secNext;
                    s_d.sectMatch = (secNext == s_q.dsec);
                end
            end else begin
                s_d.clkCnt = s_q.clkCnt + 10'h001;
            end
        end

        // --------------------------------------------------------
        // Move timing counter, wraps back to idle
        // --------------------------------------------------------
        if (sEdge) begin
            if (s_q.moveCnt == `PHASE_THREE) begin
                s_d.moveCnt = 2'h0;
            end else if (s_q.moveCnt != 2'h0) begin
                s_d.moveCnt = s_q.moveCnt + 2'h1;
            end else if (s_q.moveReq) begin
                s_d.moveCnt = `PHASE_ONE;
                case (s_q.st)
                    ST_RTC: begin
                        s_d.drv.offsetResetPulse = 1'b1;
                        s_d.armed = 1'b1;
                    end
                    ST_RECAL: begin
                        s_d.drv.recalPulse = 1'b1;
                        s_d.ccyl = `CYL_RESET;
                        s_d.armed = 1'b1;
                    end
                    default: ;
                endcase
            end
            // Seek trigger at phase two
            if (s_q.moveCnt == `PHASE_ONE && s_q.st == ST_ISEEK) begin
                s_d.drv.seekGo = 1'b1;
                s_d.armed = 1'b1;
            end
            // Phase three drops the request early
            if (s_q.moveCnt == `PHASE_TWO) begin
                s_d.moveReq = 1'b0;
                if (s_q.st == ST_RTC)
                    s_d.offsetMode = 1'b0;
            end
        end

        // --------------------------------------------------------
        // Command sequencer
        // --------------------------------------------------------
        s_d.drv.standbyReq = (s_q.st == ST_UNLOAD);
        case (s_q.st)
            ST_IDLE: ;
            ST_RTC: begin
                // Hold stays until the drive is centered
                if (s_q.armed && drvIn.offsetReady) begin
                    s_d.offsetHold = 1'b0;
                    s_d.armed = 1'b0;
                    if (s_q.retSeek) begin
                        s_d.st = ST_SEEK;
                    end else begin
                        s_d.go = 1'b0;
                        s_d.attn = 1'b1;
                        s_d.st = ST_IDLE;
                    end
                end
            end
            ST_RECAL: begin
                if (s_q.armed && drvIn.posReady) begin
                    s_d.armed = 1'b0;
                    s_d.go = 1'b0;
                    s_d.attn = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_UNLOAD: begin
                if (!drvIn.online)
                    s_d.st = ST_UNLOAD_UP;
            end
            ST_UNLOAD_UP: begin
                if (drvIn.online && drvIn.posReady) begin
                    s_d.go = 1'b0;
                    s_d.attn = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_CHECK: begin
                if (illegal) begin
                    s_d.addrErr = 1'b1;
                    s_d.go = 1'b0;
                    s_d.attn = 1'b1;
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.st = ST_SEEK;
                end
            end
            ST_SEEK: begin
                if (s_q.offsetHold && s_q.cmd != `FN_SEARCH) begin
                    // Seek or write found heads offset
                    s_d.retSeek = 1'b1;
                    s_d.moveReq = 1'b1;
                    s_d.armed = 1'b0;
                    s_d.st = ST_RTC;
                end else if (s_q.dcyl != s_q.ccyl) begin
                    // Hold has dropped before moving unless the command is a search
                    s_d.moveReq = 1'b1;
                    s_d.armed = 1'b0;
                    s_d.st = ST_ISEEK;
                end else if (s_q.cmd == `FN_SEEK) begin
                    s_d.go = 1'b0;
                    s_d.attn = 1'b1;
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.found = 1'b0;
                    s_d.st = ST_SEARCH;
                end
            end
            ST_ISEEK: begin
                if (s_q.armed && drvIn.posReady) begin
                    s_d.ccyl = s_q.dcyl;
                    s_d.armed = 1'b0;
                    s_d.st = ST_SEEK;
                end
            end
            ST_SEARCH: begin
                if (s_q.found) begin
                    s_d.go = 1'b0;
                    s_d.attn = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.cfg <= `CFG_RESET;
            s_q.ccyl <= `CYL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_rtcDone;
        s_q.st == ST_RTC && s_q.armed && drvIn.offsetReady && !s_q.retSeek;
    endsequence

    sequence s_idle2;
        !s_q.go ##0 s_q.attn ##1 s_q.st == ST_IDLE;
    endsequence

    a_rtc_reset_pulse: assert property (
        s_q.drv.offsetResetPulse |-> s_q.st == ST_RTC && s_q.moveCnt == `PHASE_ONE)
        else $error("offset reset pulse outside phase one");
    a_rtc_end_flags: assert property (
        s_rtcDone |=> s_idle2)
        else $error("centerline return did not terminate");
    a_mode_drop: assert property (
        sEdge && s_q.moveCnt == `PHASE_TWO && s_q.st == ST_RTC
            |=> !s_q.offsetMode && !s_q.moveReq)
        else $error("offset mode not dropped at phase three");
    a_recal_clear: assert property (
        s_q.drv.recalPulse |-> s_q.ccyl == `CYL_RESET && s_q.moveCnt == `PHASE_ONE)
        else $error("recal pulse without cylinder clear");
    a_unload_standby: assert property (
        s_q.st == ST_UNLOAD ##1 s_q.st == ST_UNLOAD |-> s_q.drv.standbyReq)
        else $error("standby request missing in unload");
    a_illegal_abort: assert property (
        s_q.st == ST_CHECK && illegal |=> s_q.addrErr && !s_q.go && s_q.st == ST_IDLE)
        else $error("illegal address not aborted");
    a_cyl_load: assert property (
        s_q.st == ST_ISEEK && s_q.armed && drvIn.posReady
            |=> s_q.ccyl == $past(s_q.dcyl) && s_q.st == ST_SEEK)
        else $error("current cylinder not loaded");
    a_index_clear: assert property (
        iEdge |=> s_q.sectCnt == 5'h00 && s_q.clkCnt == 10'h000 && s_q.sectPulse)
        else $error("index did not restart sector timing");
    a_found_done: assert property (
        s_q.st == ST_SEARCH && s_q.found |=> !s_q.go ##1 !s_q.go)
        else $error("search did not complete");

endmodule : disk_positioner

// ### dv/disk_drive_model.sv
// Behavioural drive: spindle timing, head moves and standby cycling
`timescale 1ns/1ns
module disk_drive_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic button,
    input wire disk_pos_pkg::drvOut_s drvOut,
    output disk_pos_pkg::drvIn_s drvIn
);
    import disk_pos_pkg::*;
    // --------------------------------
    // Mechanics state
    // --------------------------------
    logic [11:0] revCnt_q; // Position within one revolution
    logic [5:0] busy_q; // Head motion still settling
    logic online_q; // Pack spun up and heads loaded
    logic move; // Any head move pulse this cycle
    assign move = drvOut.offsetResetPulse | drvOut.recalPulse | drvOut.seekGo;
    // Spin, settle moves, cycle down on standby, up on the button
    always_ff @(posedge clock) begin
        if (rst) begin
            revCnt_q <= 12'h000;
            busy_q <= 6'h00;
            online_q <= 1'b1;
        end else begin
            revCnt_q <= revCnt_q + 12'h001;
            if (move || button) begin
                busy_q <= 6'h28;
            end else if (busy_q != 6'h00) begin
                busy_q <= busy_q - 6'h01;
            end
            if (drvOut.standbyReq) begin
                online_q <= 1'b0;
            end else if (button) begin
                online_q <= 1'b1;
            end
        end
    end
    assign drvIn.sectClk = revCnt_q[0];
    assign drvIn.indexPulse = (revCnt_q[11:2] == 10'h000);
    assign drvIn.offsetReady = (busy_q == 6'h00) && !move;
    assign drvIn.posReady = (busy_q == 6'h00) && !move && online_q;
    assign drvIn.online = online_q;
endmodule : disk_drive_model

// ### dv/disk_positioner_tb.sv
// Register-level tests of the positioner against the drive model
`timescale 1ns/1ns
`include "disk_pos_params.svh"
module disk_positioner_tb;
    import disk_pos_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic button = 1'b0;
    apbIn_s apbIn = '0;
    apbOut_s apbOut;
    drvIn_s drvIn;
    drvOut_s drvOut;
    logic [31:0] rd; // Last read data
    logic err; // Last slave error
    int errorCnt = 0;
    int comparisons = 0;
    int rtcCnt = 0; // Offset reset pulses seen
    always #5 clock = ~clock;
    disk_positioner dut_u (.clock(clock), .rst(rst), .apbIn(apbIn), .apbOut(apbOut),
        .drvIn(drvIn), .drvOut(drvOut));
    disk_drive_model drive_u (.clock(clock), .rst(rst), .button(button),
        .drvOut(drvOut), .drvIn(drvIn));
    // Count return pulses where they are settled
    always @(negedge clock) begin
        if (drvOut.offsetResetPulse === 1'b1) rtcCnt++;
    end
    task summarize;
        $display("errors %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task check(input string nm, input logic [31:0] exp, input logic [31:0] act);
        comparisons++;
        if (exp !== act) begin
            errorCnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, act);
        end
    endtask : check
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        apbIn.psel <= 1'b1;
        apbIn.penable <= 1'b0;
        apbIn.pwrite <= w;
        apbIn.paddr <= a;
        apbIn.pwdata <= d;
        @(posedge clock);
        apbIn.penable <= 1'b1;
        // Answer is taken at the rising edge that sees pready high
        do begin
            @(posedge clock);
        end while (apbOut.pready !== 1'b1);
        rd = apbOut.prdata;
        err = apbOut.pslverr;
        apbIn.psel <= 1'b0;
        apbIn.penable <= 1'b0;
    endtask : apb
    // Wait for go to clear, check and clear status
    task finish(input logic [2:0] exp);
        int n;
        n = 0;
        do begin
            apb(1'b0, `REG_STAT, 32'h0);
            n++;
        end while (rd[`STAT_GO] !== 1'b0 && n < 3000);
        check("stat", {29'h0, exp}, {29'h0, rd[2:0]});
        apb(1'b1, `REG_STAT, 32'h6);
    endtask : finish
    task run(input logic [4:0] fn, input logic [2:0] exp);
        apb(1'b1, `REG_CTRL, {26'h0, fn, 1'b1});
        finish(exp);
    endtask : run
    initial begin
        #500_000;
        errorCnt++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, `REG_CFG, 32'h0);
        check("cfg", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        check("slverr", 32'h1, {31'h0, err});
        apb(1'b1, `REG_DCYL, 32'h5);
        run(`FN_OFFSET, 3'b010);
        run(`FN_SEEK, 3'b010);
        apb(1'b0, `REG_CCYL, 32'h0);
        check("ccyl", 32'h5, rd);
        check("rtc", 32'h1, rtcCnt);
        run(`FN_OFFSET, 3'b010);
        run(`FN_RTC, 3'b010);
        apb(1'b0, `REG_STAT, 32'h0);
        check("hold", 32'h0, {31'h0, rd[`STAT_HOLD]});
        run(`FN_RECAL, 3'b010);
        apb(1'b0, `REG_CCYL, 32'h0);
        check("ccyl", 32'h0, rd);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `REG_CFG, (i == 3) ? 32'h1 : 32'h0);
            // One limit broken per pass, the others at legal values
            apb(1'b1, `REG_DCYL, (i == 0) ? 32'h19b : 32'h19a);
            apb(1'b1, `REG_DADDR, (i == 1) ? 32'h1301 : (i == 2) ? 32'h14
                : (i == 3) ? 32'h16 : 32'h0);
            run(`FN_SEARCH, 3'b110);
        end
        // Legal search at the cylinder and track limits
        apb(1'b1, `REG_CFG, 32'h0);
        apb(1'b1, `REG_DADDR, 32'h1201);
        run(`FN_SEARCH, 3'b010);
        apb(1'b0, `REG_STAT, 32'h0);
        check("found", 32'h1, {31'h0, rd[`STAT_FOUND]});
        apb(1'b0, `REG_CCYL, 32'h0);
        check("ccyl", 32'h19a, rd);
        // Write finding the heads offset returns them first
        run(`FN_OFFSET, 3'b010);
        run(`FN_WRITE, 3'b010);
        check("rtc", 32'h3, rtcCnt);
        // Diagnostic index and sector clock find sector zero at once
        apb(1'b1, `REG_DADDR, 32'h0);
        apb(1'b1, `REG_CFG, 32'h2);
        apb(1'b1, `REG_CTRL, {26'h0, `FN_SEARCH, 1'b1});
        apb(1'b1, `REG_CFG, 32'ha);
        apb(1'b1, `REG_CFG, 32'h6);
        apb(1'b0, `REG_STAT, 32'h0);
        check("diag", 32'ha, {28'h0, rd[3:0]});
        apb(1'b1, `REG_STAT, 32'h6);
        apb(1'b1, `REG_CTRL, {26'h0, `FN_UNLOAD, 1'b1});
        repeat (20) @(posedge clock);
        apb(1'b0, `REG_STAT, 32'h0);
        check("unload", 32'h1, {30'h0, rd[`STAT_ONLINE], rd[`STAT_GO]});
        button <= 1'b1;
        @(posedge clock);
        button <= 1'b0;
        finish(3'b010);
        summarize();
    end
endmodule : disk_positioner_tb
